// *** irqpe_defs.svh ***
// Offsets, field masks and reset values for the interrupt enable and priority block
`ifndef IRQPE_DEFS_SVH
`define IRQPE_DEFS_SVH

// Register indices; the byte address is four times the index
`define IRQPE_IDX_EH0 12'hFC1
`define IRQPE_IDX_EL0 12'hFC2
`define IRQPE_IDX_EH1 12'hFC4
`define IRQPE_IDX_EL1 12'hFC5
`define IRQPE_IDX_REQ2 12'hFC6
`define IRQPE_IDX_EH2 12'hFC7
`define IRQPE_IDX_EL2 12'hFC8
`define IRQPE_IDX_CTRL 12'hFD0
`define IRQPE_IDX_STAT 12'hFD1
`define IRQPE_IDX_CLR 12'hFD2
`define IRQPE_IDX_IEN 12'hFD3

// Implemented bits of each group's registers, and reset values
`define IRQPE_MASK_G0 8'h79
`define IRQPE_MASK_G1 8'hFF
`define IRQPE_MASK_G2 8'h0F
`define IRQPE_RST8 8'h00
`define IRQPE_RST_STAT 3'h0

// Control and status fields
`define IRQPE_CTRL_GLOBAL_INTERRUPT_ENABLE 0
`define IRQPE_EV_PORTC 0
`define IRQPE_EV_ACK 1
`define IRQPE_EV_RSVD 2

// Flattened source vector: group 0 at the top, group 2 at the bottom
`define IRQPE_NSRC 20
`define IRQPE_G0_BASE 5'h0C
`define IRQPE_G1_BASE 5'h04

`endif

// *** irqpe_pkg.sv ***
// Types shared by the interrupt enable and priority block
package irqpe_pkg;

	typedef enum logic [1:0] {
		LVL_OFF,
		LVL_1,
		LVL_2,
		LVL_3
	} irqpe_lvl_type;

	typedef struct packed {
		logic valid;
		logic [4:0] idx;
		logic [1:0] group;
		logic [2:0] bitpos;
		irqpe_lvl_type level;
	} irqpe_vec_type;

	typedef struct packed {
		logic wr;
		logic [11:0] idx;
	} irqpe_aphase_type;

endpackage

// *** irqpe_top.sv ***
// Interrupt request group 2, three-group enable/priority decode, arbiter and AHB-Lite register slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "irqpe_defs.svh"

module irqpe_top (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [3:0] portc_pin_request_i,
	input wire logic [7:0] pend_group0_i,
	input wire logic [7:0] pend_group1_i,
	input wire logic comparator_select_i,
	input wire logic core_ack_i,
	output logic vec_req_o,
	output logic [1:0] vec_group_o,
	output logic [2:0] vec_bit_o,
	output logic [1:0] vec_level_o,
	output logic [7:0] ack_group0_o,
	output logic [7:0] ack_group1_o,
	output logic [1:0] porta6_level_o,
	output logic [1:0] comparator_level_o,
	output logic global_interrupt_enable_o,
	output logic irq_o
);

	logic [7:0] enable_high_group0_r;
	logic [7:0] enable_low_group0_r;
	logic [7:0] enable_high_group1_r;
	logic [7:0] enable_low_group1_r;
	logic [3:0] pending_requests_group2_r;
	logic [7:0] enable_high_group2_r;
	logic [7:0] enable_low_group2_r;
	logic global_interrupt_enable_r;
	logic [2:0] status_r;
	logic [2:0] int_enable_r;
	irqpe_pkg::irqpe_aphase_type ap_r;
	irqpe_pkg::irqpe_vec_type vec_r;
	logic [31:0] hrdata_r;

	logic [7:0] enable_high_group0_nxt;
	logic [7:0] enable_low_group0_nxt;
	logic [7:0] enable_high_group1_nxt;
	logic [7:0] enable_low_group1_nxt;
	logic [3:0] pending_requests_group2_nxt;
	logic [7:0] enable_high_group2_nxt;
	logic [7:0] enable_low_group2_nxt;
	logic global_interrupt_enable_nxt;
	logic [2:0] status_nxt;
	logic [2:0] int_enable_nxt;
	irqpe_pkg::irqpe_aphase_type ap_nxt;
	irqpe_pkg::irqpe_vec_type vec_nxt;
	logic [31:0] hrdata_nxt;

	// Bus decode
	wire ap_take = hsel_i & hready_i & htrans_i[1];
	wire [7:0] wdata = hwdata_i[7:0];
	wire wr_any = ap_r.wr;
	wire wr_eh0 = wr_any & (ap_r.idx == `IRQPE_IDX_EH0);
	wire wr_el0 = wr_any & (ap_r.idx == `IRQPE_IDX_EL0);
	wire wr_eh1 = wr_any & (ap_r.idx == `IRQPE_IDX_EH1);
	wire wr_el1 = wr_any & (ap_r.idx == `IRQPE_IDX_EL1);
	wire wr_req2 = wr_any & (ap_r.idx == `IRQPE_IDX_REQ2);
	wire wr_eh2 = wr_any & (ap_r.idx == `IRQPE_IDX_EH2);
	wire wr_el2 = wr_any & (ap_r.idx == `IRQPE_IDX_EL2);
	wire wr_ctrl = wr_any & (ap_r.idx == `IRQPE_IDX_CTRL);
	wire wr_clr = wr_any & (ap_r.idx == `IRQPE_IDX_CLR);
	wire wr_ien = wr_any & (ap_r.idx == `IRQPE_IDX_IEN);
	wire [7:0] rsvd_g0 = wdata & ~`IRQPE_MASK_G0;
	wire [7:0] rsvd_g2 = wdata & ~`IRQPE_MASK_G2;
	wire rsvd_hit = ((wr_eh0 | wr_el0) & (|rsvd_g0)) |
		((wr_req2 | wr_eh2 | wr_el2) & (|rsvd_g2));

	// Acknowledge of the vector on show
	wire ack_take = core_ack_i & vec_r.valid;
	wire [19:0] ack_flat = ack_take ? (20'h00001 << vec_r.idx) : 20'h00000;
	assign ack_group0_o = ack_flat[19:12];
	assign ack_group1_o = ack_flat[11:4];
	wire [3:0] ack_group2 = ack_flat[3:0];

	// Enable and level registers
	assign enable_high_group0_nxt = wr_eh0 ? (wdata & `IRQPE_MASK_G0) : enable_high_group0_r;
	assign enable_low_group0_nxt = wr_el0 ? (wdata & `IRQPE_MASK_G0) : enable_low_group0_r;
	assign enable_high_group1_nxt = wr_eh1 ? (wdata & `IRQPE_MASK_G1) : enable_high_group1_r;
	assign enable_low_group1_nxt = wr_el1 ? (wdata & `IRQPE_MASK_G1) : enable_low_group1_r;
	assign enable_high_group2_nxt = wr_eh2 ? (wdata & `IRQPE_MASK_G2) : enable_high_group2_r;
	assign enable_low_group2_nxt = wr_el2 ? (wdata & `IRQPE_MASK_G2) : enable_low_group2_r;

	// Group-2 requests: a new pulse wins over an acknowledge or a written 0
	wire [3:0] req2_kept = wr_req2 ? wdata[3:0] : pending_requests_group2_r;
	assign pending_requests_group2_nxt = (req2_kept & ~ack_group2) | (wr_req2 ? wdata[3:0] : 4'h0) |
		portc_pin_request_i;

	// Acknowledge disables interrupts unless software enables in the same cycle
	wire global_interrupt_enable_kept = ack_take ? 1'b0 : global_interrupt_enable_r;
	assign global_interrupt_enable_nxt = wr_ctrl ? wdata[`IRQPE_CTRL_GLOBAL_INTERRUPT_ENABLE] : global_interrupt_enable_kept;

	// Sticky events; a new event wins over its clear
	wire [2:0] events;
	assign events[`IRQPE_EV_PORTC] = |portc_pin_request_i;
	assign events[`IRQPE_EV_ACK] = ack_take;
	assign events[`IRQPE_EV_RSVD] = rsvd_hit;
	wire [2:0] clr_bits = wr_clr ? wdata[2:0] : 3'h0;
	assign status_nxt = (status_r & ~clr_bits) | events;
	assign int_enable_nxt = wr_ien ? wdata[2:0] : int_enable_r;
	assign irq_o = |(status_r & int_enable_r);

	// Flattened sources; the arbiter picks the highest level, and the highest index among equal levels
	wire [19:0] pend_flat = {pend_group0_i & `IRQPE_MASK_G0, pend_group1_i, pending_requests_group2_r};
	wire [19:0] enh_flat = {enable_high_group0_r, enable_high_group1_r, enable_high_group2_r[3:0]};
	wire [19:0] enl_flat = {enable_low_group0_r, enable_low_group1_r, enable_low_group2_r[3:0]};

	// Shared source at group-1 bit 6 takes its level from the same enable pair
	wire [1:0] lvl_g1_6 = {enable_high_group1_r[6], enable_low_group1_r[6]};
	assign porta6_level_o = comparator_select_i ? 2'h0 : lvl_g1_6;
	assign comparator_level_o = comparator_select_i ? lvl_g1_6 : 2'h0;

	// Arbiter
	logic [1:0] best_lvl;
	logic [4:0] best_idx;
	logic found;
	always_comb begin
		logic [1:0] lv;
		lv = 2'h0;
		best_lvl = 2'h0;
		best_idx = 5'h00;
		found = 1'b0;
		for (int i = 0; i < `IRQPE_NSRC; i++) begin
			lv = {enh_flat[i], enl_flat[i]};
			if (pend_flat[i] && (lv != 2'h0) && (lv >= best_lvl)) begin
				best_lvl = lv;
				best_idx = 5'(i);
				found = 1'b1;
			end
		end
	end

	irqpe_pkg::irqpe_lvl_type best_level;
	always_comb begin
		unique case (best_lvl)
			2'h1: best_level = irqpe_pkg::LVL_1;
			2'h2: best_level = irqpe_pkg::LVL_2;
			2'h3: best_level = irqpe_pkg::LVL_3;
			default: best_level = irqpe_pkg::LVL_OFF;
		endcase
	end

	wire in_g0 = best_idx >= `IRQPE_G0_BASE;
	wire in_g1 = ~in_g0 & (best_idx >= `IRQPE_G1_BASE);
	wire [4:0] rel_idx = in_g0 ? (best_idx - `IRQPE_G0_BASE) :
		in_g1 ? (best_idx - `IRQPE_G1_BASE) : best_idx;

	// A request shown but just acknowledged is not shown again
	wire ack_same = ack_take & (vec_r.idx == best_idx);
	always_comb begin
		vec_nxt.valid = found & global_interrupt_enable_r & ~ack_take & ~ack_same;
		vec_nxt.idx = best_idx;
		vec_nxt.group = in_g0 ? 2'h0 : (in_g1 ? 2'h1 : 2'h2);
		vec_nxt.bitpos = rel_idx[2:0];
		vec_nxt.level = best_level;
	end

	assign vec_req_o = vec_r.valid;
	assign vec_group_o = vec_r.group;
	assign vec_bit_o = vec_r.bitpos;
	assign vec_level_o = vec_r.level;
	assign global_interrupt_enable_o = global_interrupt_enable_r;

	// Read data is taken at the address phase from next-state values
	assign ap_nxt.wr = ap_take & hwrite_i;
	assign ap_nxt.idx = haddr_i[13:2];
	wire [11:0] rd_idx = haddr_i[13:2];
	wire rd_take = ap_take & ~hwrite_i;
	logic [7:0] rd_byte;
	always_comb begin
		unique case (rd_idx)
			`IRQPE_IDX_EH0: rd_byte = enable_high_group0_nxt;
			`IRQPE_IDX_EL0: rd_byte = enable_low_group0_nxt;
			`IRQPE_IDX_EH1: rd_byte = enable_high_group1_nxt;
			`IRQPE_IDX_EL1: rd_byte = enable_low_group1_nxt;
			`IRQPE_IDX_REQ2: rd_byte = {4'h0, pending_requests_group2_nxt};
			`IRQPE_IDX_EH2: rd_byte = enable_high_group2_nxt;
			`IRQPE_IDX_EL2: rd_byte = enable_low_group2_nxt;
			`IRQPE_IDX_CTRL: rd_byte = {7'h00, global_interrupt_enable_nxt};
			`IRQPE_IDX_STAT: rd_byte = {5'h00, status_nxt};
			`IRQPE_IDX_IEN: rd_byte = {5'h00, int_enable_nxt};
			default: rd_byte = 8'h00;
		endcase
	end
	assign hrdata_nxt = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

	assign hrdata_o = hrdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			enable_high_group0_r <= `IRQPE_RST8;
			enable_low_group0_r <= `IRQPE_RST8;
			enable_high_group1_r <= `IRQPE_RST8;
			enable_low_group1_r <= `IRQPE_RST8;
			pending_requests_group2_r <= 4'h0;
			enable_high_group2_r <= `IRQPE_RST8;
			enable_low_group2_r <= `IRQPE_RST8;
		end else begin
			enable_high_group0_r <= enable_high_group0_nxt;
			enable_low_group0_r <= enable_low_group0_nxt;
			enable_high_group1_r <= enable_high_group1_nxt;
			enable_low_group1_r <= enable_low_group1_nxt;
			pending_requests_group2_r <= pending_requests_group2_nxt;
			enable_high_group2_r <= enable_high_group2_nxt;
			enable_low_group2_r <= enable_low_group2_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			global_interrupt_enable_r <= 1'b0;
			status_r <= `IRQPE_RST_STAT;
			int_enable_r <= `IRQPE_RST_STAT;
			vec_r <= '0;
		end else begin
			global_interrupt_enable_r <= global_interrupt_enable_nxt;
			status_r <= status_nxt;
			int_enable_r <= int_enable_nxt;
			vec_r <= vec_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ap_r <= '0;
			hrdata_r <= 32'h00000000;
		end else begin
			ap_r <= ap_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

endmodule

// *** irqpe_chk.sv ***
// Port checker for the interrupt enable and priority block
`timescale 1ns/1ps
module irqpe_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic comparator_select_i,
	input wire logic core_ack_i,
	input wire logic vec_req_o,
	input wire logic [1:0] vec_group_o,
	input wire logic [2:0] vec_bit_o,
	input wire logic [1:0] vec_level_o,
	input wire logic [7:0] ack_group0_o,
	input wire logic [7:0] ack_group1_o,
	input wire logic [1:0] porta6_level_o,
	input wire logic [1:0] comparator_level_o,
	input wire logic global_interrupt_enable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_ack;
		vec_req_o && core_ack_i;
	endsequence
	sequence s_drop;
		!vec_req_o && !global_interrupt_enable_o;
	endsequence
	a_ack_drops: assert property (s_ack |=> s_drop)
		else $error("vector held after acknowledge");
	a_off_quiet: assert property (!global_interrupt_enable_o && !$past(global_interrupt_enable_o) |-> !vec_req_o)
		else $error("vector while disabled");
	a_ack_hot0: assert property (vec_req_o && core_ack_i && vec_group_o == 2'h0 |-> ack_group0_o == 8'h01 << vec_bit_o)
		else $error("group0 ack wrong");
	a_ack_hot1: assert property (vec_req_o && core_ack_i && vec_group_o == 2'h1 |-> ack_group1_o == 8'h01 << vec_bit_o)
		else $error("group1 ack wrong");
	a_no_stray: assert property (!(vec_req_o && core_ack_i) |-> ack_group0_o == 8'h00 && ack_group1_o == 8'h00)
		else $error("stray ack");
	a_level_set: assert property (vec_req_o |-> vec_level_o != 2'h0)
		else $error("vector with no level");
	a_legal_src: assert property (vec_req_o |-> vec_group_o != 2'h3 && !(vec_group_o == 2'h2 && vec_bit_o > 3'h3)
		&& !(vec_group_o == 2'h0 && vec_bit_o inside {3'h1, 3'h2, 3'h7}))
		else $error("vector from reserved bit");
	a_shared_rt: assert property (comparator_select_i ? porta6_level_o == 2'h0 : comparator_level_o == 2'h0)
		else $error("shared level misrouted");
	a_bus_okay: assert property (hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h0)
		else $error("bus answer wrong");
endmodule
bind irqpe_top irqpe_chk u_chk (.core_clk_i, .rst_n_i, .hrdata_o, .hreadyout_o, .hresp_o, .comparator_select_i,
	.core_ack_i, .vec_req_o, .vec_group_o, .vec_bit_o, .vec_level_o, .ack_group0_o, .ack_group1_o,
	.porta6_level_o, .comparator_level_o, .global_interrupt_enable_o);

// *** irqpe_core.sv ***
// Core model that acknowledges a shown vector after a set delay
`timescale 1ns/1ps
module irqpe_core (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic vec_req_i,
	input wire logic [3:0] dly_i,
	output logic ack_o
);
	logic [3:0] cnt_r;
	initial ack_o = 1'b0;
	// One-cycle acknowledge, only while a vector is shown
	always @(posedge clk_i) begin
		if (!rst_n_i || !vec_req_i || ack_o) begin
			ack_o <= 1'b0;
			cnt_r <= 4'h0;
		end else if (cnt_r == dly_i)
			ack_o <= 1'b1;
		else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule

// *** tb.sv ***
// Testbench for the interrupt enable and priority block
`timescale 1ns/1ps
`include "irqpe_defs.svh"
module tb;
	logic clk = 0, rst_n = 0, hsel = 0, hw = 0, cs = 0, cack, vr, ge, irq, rdy, rsp;
	logic [1:0] ht = 0, vg, vl, l6, lc;
	logic [2:0] vb;
	logic [3:0] pc = 0, dly = 0;
	logic [7:0] p0 = 0, p1 = 0, a0, a1;
	logic [31:0] ha = 0, hwd = 0, hrd;
	int n_errors = 0, total_checks = 0;
	logic [11:0] ix[7] = '{`IRQPE_IDX_EH0, `IRQPE_IDX_EL0, `IRQPE_IDX_EH1, `IRQPE_IDX_EL1,
		`IRQPE_IDX_REQ2, `IRQPE_IDX_EH2, `IRQPE_IDX_EL2};
	logic [7:0] mk[7] = '{8'h79, 8'h79, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F};
	logic [6:0] ev[3] = '{{2'h2, 3'h0, 2'h3}, {2'h1, 3'h7, 2'h2}, {2'h0, 3'h6, 2'h1}};
	always #10 clk = ~clk;
	irqpe_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(ha), .htrans_i(ht),
		.hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy),
		.hresp_o(rsp), .portc_pin_request_i(pc), .pend_group0_i(p0), .pend_group1_i(p1),
		.comparator_select_i(cs), .core_ack_i(cack), .vec_req_o(vr), .vec_group_o(vg), .vec_bit_o(vb),
		.vec_level_o(vl), .ack_group0_o(a0), .ack_group1_o(a1), .porta6_level_o(l6),
		.comparator_level_o(lc), .global_interrupt_enable_o(ge), .irq_o(irq));
	irqpe_core CORE (.clk_i(clk), .rst_n_i(rst_n), .vec_req_i(vr), .dly_i(dly), .ack_o(cack));
	// Neighbour latches drop a request when it is acknowledged
	always @(posedge clk) if ((a0 | a1) != 8'h00) begin
		p0 <= p0 & ~a0;
		p1 <= p1 & ~a1;
	end
	task chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_sim;
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task bus(logic [11:0] i, logic w, logic [7:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1;
		ha <= {18'h0, i, 2'h0};
		ht <= 2'h2;
		hw <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		ht <= 2'h0;
		hwd <= {24'h0, d};
		do @(posedge clk); while (rdy !== 1'b1);
		r = hrd;
	endtask
	task wr(logic [11:0] i, logic [7:0] d);
		logic [31:0] x;
		bus(i, 1, d, x);
	endtask
	task rd(string n, logic [11:0] i, logic [31:0] e);
		logic [31:0] x;
		bus(i, 0, 8'h00, x);
		chk(n, e, x);
	endtask
	task wv(logic [6:0] e);
		int k;
		for (k = 0; k < 50 && vr !== 1'b1; k++) @(negedge clk);
		chk("vector", e, {vg, vb, vl});
		for (k = 0; k < 50 && vr !== 1'b0; k++) @(negedge clk);
		chk("vector dropped", 0, vr);
	endtask
	task t_regs;
		for (int i = 0; i < 7; i++) begin
			rd("reset value", ix[i], 0);
			wr(ix[i], 8'hFF);
			rd("implemented bits", ix[i], mk[i]);
			wr(ix[i], 8'h00);
			rd("cleared", ix[i], 0);
		end
		rd("unmapped", 12'hF00, 0);
	endtask
	task t_poll;
		wr(`IRQPE_IDX_EH2, 8'h0F);
		@(posedge clk);
		pc <= 4'h4;
		@(posedge clk);
		pc <= 4'h0;
		rd("polled request", `IRQPE_IDX_REQ2, 4);
		@(negedge clk);
		chk("vector while disabled", 0, vr);
		wr(`IRQPE_IDX_REQ2, 8'h00);
	endtask
	task t_irq;
		wr(`IRQPE_IDX_CLR, 8'h07);
		wr(`IRQPE_IDX_IEN, 8'h01);
		@(posedge clk);
		pc <= 4'h2;
		@(posedge clk);
		pc <= 4'h0;
		@(negedge clk);
		chk("irq raised", 1, irq);
		wr(`IRQPE_IDX_IEN, 8'h00);
		@(negedge clk);
		chk("irq masked", 0, irq);
		wr(`IRQPE_IDX_IEN, 8'h01);
		wr(`IRQPE_IDX_CLR, 8'h01);
		@(negedge clk);
		chk("irq cleared", 0, irq);
		wr(`IRQPE_IDX_REQ2, 8'h00);
	endtask
	task t_prio;
		wr(`IRQPE_IDX_EL0, 8'h40);
		wr(`IRQPE_IDX_EH1, 8'h80);
		wr(`IRQPE_IDX_EH2, 8'h01);
		wr(`IRQPE_IDX_EL2, 8'h01);
		p0 <= 8'h40;
		p1 <= 8'h80;
		wr(`IRQPE_IDX_REQ2, 8'h01);
		for (int k = 0; k < 3; k++) begin
			dly <= 4'(k * 3);
			wr(`IRQPE_IDX_CTRL, 8'h01);
			wv(ev[k]);
		end
		rd("request after ack", `IRQPE_IDX_REQ2, 0);
		rd("enable after ack", `IRQPE_IDX_CTRL, 0);
		rd("ack status", `IRQPE_IDX_STAT, 2);
	endtask
	task t_shared;
		wr(`IRQPE_IDX_EH1, 8'h40);
		wr(`IRQPE_IDX_EL1, 8'h40);
		for (int k = 0; k < 2; k++) begin
			cs <= k[0];
			@(negedge clk);
			chk("comparator level", k ? 3 : 0, lc);
			chk("port a6 level", k ? 0 : 3, l6);
		end
	endtask
	initial begin
		#200000;
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_regs;
		t_poll;
		t_irq;
		t_prio;
		t_shared;
		end_sim;
	end
endmodule
